// [bench/ccs_code_mem.sv]
// Code store on the far side of the bus.
// Assumes the sequencer samples codeData while fetchStrobe is high.
`timescale 1ns/1ps
module ccs_code_mem (
  input wire logic [15:0] programCounter,
  input wire logic fetchStrobe,
  output logic [7:0] codeData
);
  logic [7:0] rom [10] = '{8'hC3, 8'hD2, 8'h20, 8'hE0, 8'hB6, 8'h12,
    8'h34, 8'hD5, 8'h30, 8'h00};
  logic [7:0] cur;
  // Outside a fetch the bus shows the inverse, so a late sample shows up.
  always_comb begin
    cur = programCounter < 16'h000A ? rom[programCounter[3:0]] : 8'hC3;
    codeData = fetchStrobe ? cur : ~cur;
  end
endmodule

// [bench/ccs_sequencer_properties.sv]
// Port timing checks for the machine cycle sequencer.
// Assumes one core clock and an active-high asynchronous reset.
`timescale 1ns/1ps
module ccs_sequencer_properties (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic resetPin,
  input wire logic externalProgram,
  input wire logic intPending,
  input wire logic [15:0] programCounter,
  input wire logic [2:0] stateNum,
  input wire logic phaseTwo,
  input wire logic fetchStrobe,
  input wire logic program_read_strobe_n,
  input wire logic dataBusCycle,
  input wire logic instrDone,
  input wire logic cpuClockEnable,
  input wire logic idleMode
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  AST_WRAP:
  assert property (cpuClockEnable && phaseTwo && stateNum == 3'h5
    |=> stateNum == 3'h0 || idleMode) else $error("no wrap");
  AST_FETCH:
  assert property (fetchStrobe |-> !phaseTwo
    && (stateNum == 3'h0 || stateNum == 3'h3)) else $error("bad fetch");
  AST_STROBE:
  assert property (fetchStrobe && externalProgram && !resetPin
    |=> !program_read_strobe_n) else $error("no strobe");
  AST_DATA:
  assert property (dataBusCycle && stateNum == 3'h3 |-> !fetchStrobe)
    else $error("fetch in data cycle");
  AST_DONE:
  assert property (instrDone |-> phaseTwo && stateNum == 3'h5)
    else $error("done off state six");
  AST_CLK:
  assert property (idleMode |-> !cpuClockEnable) else $error("clock on");
  AST_HOLD:
  assert property (idleMode ##1 idleMode && !resetPin
    |-> $stable(programCounter)) else $error("pc moved");
  AST_WAKE:
  assert property (idleMode && intPending && !resetPin
    |-> ##[1:24] !idleMode) else $error("no wake");
endmodule

// [bench/cpu_cycle_sequencer_idle_tb.sv]
// Bench for the machine cycle sequencer with a code store on its bus.
// Assumes the sequencer, code store and checker are compiled first.
`timescale 1ns/1ps
module cpu_cycle_sequencer_idle_tb;
  logic core_clk = 0, rst = 1, resetPin = 0, externalProgram = 1;
  logic powerWrite = 0, intPending = 0;
  logic [7:0] powerWriteData = 8'h00, codeData, instructionReg;
  logic [7:0] power_control_register;
  logic [15:0] programCounter;
  logic [2:0] stateNum;
  logic phaseTwo, fetchStrobe, program_read_strobe_n, dataBusCycle;
  logic instrDone, cpuClockEnable, idleMode, intService;
  int fails = 0, cmp_count = 0, clks = 0, strb = 0, dat = 0, wake = 0;
  ccs_sequencer i_dut (.core_clk, .rst, .resetPin, .codeData,
    .externalProgram, .powerWrite, .powerWriteData, .intPending,
    .programCounter, .instructionReg, .stateNum, .phaseTwo, .fetchStrobe,
    .program_read_strobe_n, .dataBusCycle, .instrDone, .cpuClockEnable,
    .idleMode, .power_control_register, .intService);
  ccs_code_mem i_mem (.programCounter, .fetchStrobe, .codeData);
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    clks <= clks + 1;
    strb <= strb + int'(!program_read_strobe_n);
    dat <= dat + int'(dataBusCycle);
    wake <= wake + int'(intService);
  end
  task automatic print_verdict;
    $display("fails %0d compares %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(string nm, logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic waitFor(ref logic s, input logic v);
    @(negedge core_clk);
    for (int i = 0; i < 60 && s !== v; i++) @(negedge core_clk);
    if (s !== v) begin
      fails++;
      print_verdict();
    end
  endtask
  // One pass over the code store; interval counts start at the first end.
  task automatic runProg(input logic ext);
    int t, s, d;
    logic [7:0] len [5] = '{8'h0C, 8'h18, 8'h18, 8'h18, 8'h0C};
    logic [7:0] str [5] = '{8'h02, 8'h02, 8'h04, 8'h04, 8'h02};
    tick(1);
    externalProgram = ext;
    rst = 1;
    tick(10);
    rst = 0;
    waitFor(instrDone, 1'b1);
    check("pc", programCounter, 16'h0001);
    for (int k = 0; k < 5; k++) begin
      t = clks;
      s = strb;
      d = dat;
      waitFor(instrDone, 1'b1);
      check("clocks", 16'(clks - t), 16'(len[k]));
      check("strobes", 16'(strb - s), ext ? 16'(str[k]) : 16'h0000);
      if (k == 0) check("ir", 16'(instructionReg), 16'h00D2);
      if (k == 0) check("pc", programCounter, 16'h0003);
      if (k == 1) check("pc", programCounter, 16'h0004);
      if (k == 1) check("data", 16'(dat != d), 16'h0001);
    end
  endtask
  task automatic enterIdle;
    tick(1);
    powerWriteData = 8'h01;
    powerWrite = 1;
    tick(1);
    powerWrite = 0;
    waitFor(idleMode, 1'b1);
    check("pcr", 16'(power_control_register), 16'h0001);
  endtask
  task automatic idleWake;
    logic [15:0] hold;
    enterIdle();
    hold = programCounter;
    tick(30);
    check("hold", programCounter, hold);
    check("clken", 16'(cpuClockEnable), 16'h0000);
    intPending = 1;
    waitFor(idleMode, 1'b0);
    check("pcr", 16'(power_control_register), 16'h0000);
    tick(2);
    intPending = 0;
    check("wake", 16'(wake != 0), 16'h0001);
  endtask
  task automatic idleReset;
    enterIdle();
    tick(1);
    resetPin = 1;
    tick(30);
    check("pc", programCounter, 16'h0000);
    check("strobe", 16'(program_read_strobe_n), 16'h0001);
    check("pcr", 16'(power_control_register), 16'h0000);
    resetPin = 0;
    waitFor(instrDone, 1'b1);
    check("idle", 16'(idleMode), 16'h0000);
  endtask
  initial begin
    runProg(1'b1);
    runProg(1'b0);
    idleWake();
    idleReset();
    print_verdict();
  end
endmodule
bind ccs_sequencer ccs_sequencer_properties i_props (.core_clk, .rst,
  .resetPin, .externalProgram, .intPending, .programCounter, .stateNum,
  .phaseTwo, .fetchStrobe, .program_read_strobe_n, .dataBusCycle,
  .instrDone, .cpuClockEnable, .idleMode);

// [shared/ccs_pkg.sv]
// Constants and types for the cycle sequencer, four of them unused there; its opcode table uses none of them.
// Assumes one core clock; each oscillator period is one core clock edge.
//
// Contract
// - Six states, first through sixth, repeat for every machine cycle.
// - Each state lasts two oscillator periods; twelve per machine cycle.
// - Every state splits into phase one and phase two halves.
// - Two program fetches every machine cycle, needed or not, except the second cycle of an external data move.
// - Surplus fetched byte discarded; program counter stays unchanged.
// - One-cycle opcode loads into instruction register during state one.
// - Second program fetch happens during state four.
// - One-cycle instruction completes at end of state six.
// - External data move takes two cycles; no fetch in second.
// - Only the second external data move cycle skips fetches.
// - Same sequence and timing for internal or external program memory.
// - External program memory: read strobe pulses twice per fetching cycle.
// - External data access omits two read strobe pulses.
// - Data bus cycle lasts twice a program bus cycle.
// - Compare-jump and decrement-jump direct forms: three bytes, 24 clocks.
// - Writing one to power control bit zero enters idle after instruction.
// - Idle stops processor clock; peripherals keep running.
// - Idle holds all processor registers and port pin states.
// - Enabled interrupt in idle clears idle bit and resumes.
// - Reset in idle loads program counter zero and resets registers.
// - External data moves of every form take 24 clocks.
package ccs_pkg;

  localparam int CLK_MHZ = 20;
  localparam logic [3:0] OSC_PER_MC = 4'hC;
  localparam logic [2:0] STATE_COUNT = 3'h6;
  localparam logic [4:0] RESET_HOLD_CLKS = 5'h18;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] IR_RESET = 8'h00;
  localparam logic [7:0] PWR_RESET = 8'h00;
  localparam int PWR_IDLE_BIT = 0;
  localparam logic [1:0] RST_SAMPLE_MC = 2'h2;

  typedef enum logic [2:0] {
    CCS_S1 = 3'b000,
    CCS_S2 = 3'b001,
    CCS_S3 = 3'b010,
    CCS_S4 = 3'b011,
    CCS_S5 = 3'b100,
    CCS_S6 = 3'b101
  } ccs_state_e;

endpackage

// [verilog/ccs_opcode_rom.sv]
// Opcode attribute table: byte length, machine cycles, data move flag.
// Assumes an opcode presented each clock; result registered one edge later.
`timescale 1ns/1ps
module ccs_opcode_rom (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] opcode,
  output logic [1:0] byteLen,
  output logic twoCycle,
  output logic isDataMove
);

  logic [1:0] lenNext;
  logic twoNext;
  logic moveNext;

  always_comb begin
    lenNext = 2'h1;
    twoNext = 1'b0;
    moveNext = 1'b0;
    // Low five bits 0x01/0x11 select the absolute jump and call groups.
    if (opcode[3:0] == 4'h1) begin
      lenNext = 2'h2;
      twoNext = 1'b1;
    end else if (opcode[7:4] == 4'hB && opcode[3:2] != 2'b00) begin
      lenNext = 2'h3;
      twoNext = 1'b1;
    end else if (opcode[7:3] == 5'b11011) begin
      lenNext = 2'h2;
      twoNext = 1'b1;
    end else begin
      case (opcode)
        8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3: begin
          twoNext = 1'b1;
          moveNext = 1'b1;
        end
        8'hC5, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'h92, 8'h80, 8'h60, 8'h70,
        8'h40, 8'h50: begin
          lenNext = 2'h2;
          twoNext = 1'b1;
        end
        8'hC2, 8'hD2, 8'hB2, 8'hA2: begin
          lenNext = 2'h2;
        end
        8'h12, 8'h02, 8'h20, 8'h30, 8'h10, 8'hB4, 8'hB5, 8'hD5: begin
          lenNext = 2'h3;
          twoNext = 1'b1;
        end
        8'h22, 8'h32, 8'h73, 8'h93, 8'h83: begin
          twoNext = 1'b1;
        end
        default: begin
          lenNext = 2'h1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      byteLen <= 2'h1;
      twoCycle <= 1'b0;
      isDataMove <= 1'b0;
    end else begin
      byteLen <= lenNext;
      twoCycle <= twoNext;
      isDataMove <= moveNext;
    end
  end

endmodule

// [verilog/ccs_sequencer.sv]
// Machine cycle sequencer: six states of two phases, two fetches per cycle except the second cycle of a data move.
// Assumes synchronous inputs; code bytes arrive on codeData during fetch.
`timescale 1ns/1ps
module ccs_sequencer (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic resetPin,
  input wire logic [7:0] codeData,
  input wire logic externalProgram,
  input wire logic powerWrite,
  input wire logic [7:0] powerWriteData,
  input wire logic intPending,
  output logic [15:0] programCounter,
  output logic [7:0] instructionReg,
  output logic [2:0] stateNum,
  output logic phaseTwo,
  output logic fetchStrobe,
  output logic program_read_strobe_n,
  output logic dataBusCycle,
  output logic instrDone,
  output logic cpuClockEnable,
  output logic idleMode,
  output logic [7:0] power_control_register,
  output logic intService
);

  ccs_pkg::ccs_state_e stateReg;
  ccs_pkg::ccs_state_e stateNext;
  logic phaseReg;
  logic secondCycle_reg;
  logic [1:0] bytesLeft_reg;
  logic [1:0] romLen;
  logic romTwo;
  logic romMove;
  logic romTwoHeld;
  logic romMoveHeld;
  logic moveCycle;
  logic fetchS1;
  logic fetchS4;
  logic opcodeFetch;
  logic cycleStart;
  logic endOfCycle;
  logic [4:0] rstCount_reg;
  logic [4:0] rstCount_next;
  logic internalReset;
  logic strobeNext;
  logic dataNext;
  logic idleReg;
  logic idlePend_reg;
  logic powerLoad;
  logic idleEnter;
  logic idleWake;

  // Schedule of one machine cycle, two clocks per state:
  //   S1P1  opcode or operand fetch; the strobe goes low on the next edge.
  //   S1P2  attributes of a new opcode are captured from the table.
  //   S2 and S3 carry no fetch.
  //   S4P1  second fetch; kept only if the instruction wants the byte.
  //   S5 carries no fetch.
  //   S6P2  end of cycle; a finished instruction raises instrDone.
  // The second cycle of an external data move has no fetch at all, so
  // the shared bus is free for the data transfer.

  // The pin must stay high for the whole hold window before the core is
  // reset; a short glitch on the pin restarts the count from zero.
  always_comb begin
    rstCount_next = rstCount_reg;
    if (!resetPin) begin
      rstCount_next = 5'h00;
    end else if (rstCount_reg != ccs_pkg::RESET_HOLD_CLKS) begin
      rstCount_next = rstCount_reg + 5'h01;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rstCount_reg <= 5'h00;
    end else begin
      rstCount_reg <= rstCount_next;
    end
  end

  // The count saturates, so the reset stays applied while the pin is high
  // and execution restarts from address zero once the pin falls.
  assign internalReset =
    (rstCount_reg == ccs_pkg::RESET_HOLD_CLKS);

  // The table registers its result, so attributes lag the bus by a clock.
  ccs_opcode_rom u_rom (
    .core_clk(core_clk),
    .rst(rst),
    .opcode(codeData),
    .byteLen(romLen),
    .twoCycle(romTwo),
    .isDataMove(romMove)
  );

  // Only the processor side stops in idle; the peripheral blocks of the
  // device keep their own clock and are not modelled here.
  assign cpuClockEnable = !idleReg;
  assign idleMode = idleReg;

  // The sixth state and any stray code both lead back to the first state.
  always_comb begin
    stateNext = ccs_pkg::CCS_S1;
    case (stateReg)
      ccs_pkg::CCS_S1: begin
        stateNext = ccs_pkg::CCS_S2;
      end
      ccs_pkg::CCS_S2: begin
        stateNext = ccs_pkg::CCS_S3;
      end
      ccs_pkg::CCS_S3: begin
        stateNext = ccs_pkg::CCS_S4;
      end
      ccs_pkg::CCS_S4: begin
        stateNext = ccs_pkg::CCS_S5;
      end
      ccs_pkg::CCS_S5: begin
        stateNext = ccs_pkg::CCS_S6;
      end
      default: begin
        stateNext = ccs_pkg::CCS_S1;
      end
    endcase
  end

  // Phase flips on every running clock; a frozen core keeps its phase.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      phaseReg <= 1'b0;
    end else if (internalReset) begin
      phaseReg <= 1'b0;
    end else if (!idleReg) begin
      phaseReg <= !phaseReg;
    end
  end

  // State advances on phase two only, so a state spans two clocks.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stateReg <= ccs_pkg::CCS_S1;
    end else if (internalReset) begin
      stateReg <= ccs_pkg::CCS_S1;
    end else if (!idleReg && phaseReg) begin
      stateReg <= stateNext;
    end
  end

  assign stateNum = stateReg;
  assign phaseTwo = phaseReg;
  assign endOfCycle = !idleReg && phaseReg &&
    (stateReg == ccs_pkg::CCS_S6);

  // Fetch points: state one and state four, phase one, unless this is the
  // second cycle of an external data move or the core is idle or held in reset.
  // Timing never depends on whether the code came from inside or outside.
  assign moveCycle = secondCycle_reg && romMoveHeld;
  always_comb begin
    fetchS1 = 1'b0;
    fetchS4 = 1'b0;
    if (!idleReg && !internalReset && !phaseReg && !moveCycle) begin
      case (stateReg)
        ccs_pkg::CCS_S1: begin
          fetchS1 = 1'b1;
        end
        ccs_pkg::CCS_S2: begin
          fetchS1 = 1'b0;
        end
        ccs_pkg::CCS_S3: begin
          fetchS1 = 1'b0;
        end
        ccs_pkg::CCS_S4: begin
          fetchS4 = 1'b1;
        end
        ccs_pkg::CCS_S5: begin
          fetchS4 = 1'b0;
        end
        default: begin
          fetchS4 = 1'b0;
        end
      endcase
    end
  end
  assign fetchStrobe = fetchS1 || fetchS4;
  assign opcodeFetch = fetchS1 && !secondCycle_reg;

  // Strobe is low for one clock per fetch on external code; the data
  // move cycle drops both pulses to free the shared bus.
  assign strobeNext = !(externalProgram && fetchStrobe);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      program_read_strobe_n <= 1'b1;
    end else begin
      program_read_strobe_n <= strobeNext;
    end
  end

  // The data cycle holds the bus across all six states of the second
  // cycle, twice the three-state span of a program fetch.
  assign dataNext = moveCycle && !idleReg && !internalReset;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dataBusCycle <= 1'b0;
    end else begin
      dataBusCycle <= dataNext;
    end
  end

  // Attributes of a new opcode are settled one clock after its fetch,
  // so a first cycle captures them at S1P2.
  assign cycleStart = !idleReg && phaseReg &&
    (stateReg == ccs_pkg::CCS_S1) && !secondCycle_reg;

  // Only the first fetch of a first cycle carries an opcode; the first
  // fetch of a second cycle is an operand byte.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      instructionReg <= ccs_pkg::IR_RESET;
    end else if (internalReset) begin
      instructionReg <= ccs_pkg::IR_RESET;
    end else if (opcodeFetch) begin
      instructionReg <= codeData;
    end
  end

  // The counter moves only for bytes the instruction consumes; the
  // surplus fetch of a short instruction leaves it where it is.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      programCounter <= ccs_pkg::PC_RESET;
    end else if (internalReset) begin
      programCounter <= ccs_pkg::PC_RESET;
    end else if (opcodeFetch) begin
      programCounter <= programCounter + 16'h0001;
    end else if (fetchStrobe && bytesLeft_reg != 2'h0) begin
      programCounter <= programCounter + 16'h0001;
    end
  end

  // Operand bytes still owed by the current instruction; fetches beyond
  // them are ignored.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bytesLeft_reg <= 2'h0;
    end else if (internalReset) begin
      bytesLeft_reg <= 2'h0;
    end else if (cycleStart) begin
      bytesLeft_reg <= romLen - 2'h1;
    end else if (fetchStrobe && !opcodeFetch &&
        bytesLeft_reg != 2'h0) begin
      bytesLeft_reg <= bytesLeft_reg - 2'h1;
    end
  end

  // Opcode attributes are held for the whole instruction, because the
  // table output follows whatever byte is on the bus.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      romTwoHeld <= 1'b0;
      romMoveHeld <= 1'b0;
    end else if (internalReset) begin
      romTwoHeld <= 1'b0;
      romMoveHeld <= 1'b0;
    end else if (cycleStart) begin
      romTwoHeld <= romTwo;
      romMoveHeld <= romMove;
    end
  end

  // A two-cycle opcode marks its second machine cycle at the S6P2 edge.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      secondCycle_reg <= 1'b0;
    end else if (internalReset) begin
      secondCycle_reg <= 1'b0;
    end else if (endOfCycle) begin
      secondCycle_reg <= !secondCycle_reg && romTwoHeld;
    end
  end

  assign instrDone = endOfCycle && (secondCycle_reg || !romTwoHeld);

  // Power control and idle: entry waits for the end of the writing
  // instruction, so that instruction still completes first.
  assign powerLoad = powerWrite && !idleReg;
  assign idleEnter = idlePend_reg && instrDone;
  assign idleWake = idleReg && intPending;

  // Writes are refused while idle, so a wake never meets a write.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      power_control_register <= ccs_pkg::PWR_RESET;
    end else if (internalReset) begin
      power_control_register <= ccs_pkg::PWR_RESET;
    end else if (idleWake) begin
      power_control_register[ccs_pkg::PWR_IDLE_BIT] <= 1'b0;
    end else if (powerLoad) begin
      power_control_register <= powerWriteData;
    end
  end

  // A new write wins over the entry that clears the pending request.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      idlePend_reg <= 1'b0;
    end else if (internalReset) begin
      idlePend_reg <= 1'b0;
    end else if (powerLoad) begin
      idlePend_reg <= powerWriteData[ccs_pkg::PWR_IDLE_BIT];
    end else if (idleEnter) begin
      idlePend_reg <= 1'b0;
    end
  end

  // The core freezes at S1P1 of the next cycle, so it resumes with a
  // fresh opcode fetch after a wake.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      idleReg <= 1'b0;
    end else if (internalReset) begin
      idleReg <= 1'b0;
    end else if (idleWake) begin
      idleReg <= 1'b0;
    end else if (idleEnter) begin
      idleReg <= 1'b1;
    end
  end

  // One pulse marks the hand-over to the service routine on a wake.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      intService <= 1'b0;
    end else if (internalReset) begin
      intService <= 1'b0;
    end else begin
      intService <= idleWake;
    end
  end

endmodule
